/* File: rtl/ncfg_regs.svh */
// Offsets, field positions, reset values and limits of the network configuration space
`ifndef NCFG_REGS_SVH
`define NCFG_REGS_SVH

// ----------------------------------------------------------------
// Word offsets of the configuration space
// ----------------------------------------------------------------
`define NCFG_OFS_ADDR_LO      8'h00
`define NCFG_OFS_ADDR_HI      8'h04
`define NCFG_OFS_QP_MTU       8'h08
`define NCFG_OFS_RATE         8'h0c
`define NCFG_OFS_DUPLEX_RSS   8'h10
`define NCFG_OFS_HASH_KINDS   8'h14
`define NCFG_OFS_ENCAP_KINDS  8'h18
`define NCFG_OFS_OFFER        8'h20
`define NCFG_OFS_STATE        8'h24

// ----------------------------------------------------------------
// Field positions of the offer and state registers
// ----------------------------------------------------------------
`define NCFG_OFFER_WIDTH      11
`define NCFG_STATE_LINK_BIT   24

// ----------------------------------------------------------------
// Link state flag values and codes
// ----------------------------------------------------------------
`define NCFG_FLAG_LINK_UP     16'h0001
`define NCFG_FLAG_ANNOUNCE    16'h0002
`define NCFG_RATE_MAX         32'h7fffffff
`define NCFG_RATE_UNKNOWN     32'hffffffff
`define NCFG_DUPLEX_FULL      8'h01
`define NCFG_DUPLEX_HALF      8'h00
`define NCFG_DUPLEX_UNKNOWN   8'hff

// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define NCFG_QP_MIN           16'h0001
`define NCFG_QP_MAX           17'h08000
`define NCFG_MTU_MIN          16'h0044
`define NCFG_MTU_MAX          16'hffff
`define NCFG_MTU_DEFAULT      16'h05dc
`define NCFG_KEY_MIN          8'h28
`define NCFG_TABLE_MIN        16'h0080
`define NCFG_ETH_HDR_LEN      17'h0000e
`define NCFG_OFFER_RESET      11'h000

`endif

/* File: rtl/ncfg_pkg.sv */
// Types shared by the network configuration space
package ncfg_pkg;

    // Offered features and access mode, as held in the offer register
    typedef struct packed {
        logic mtu_negotiated;
        logic guest_big_endian;
        logic legacy;
        logic hash_tunnel;
        logic hash_report;
        logic speed_duplex;
        logic mtu;
        logic rss;
        logic multiqueue;
        logic status;
        logic station;
    } ncfg_offer_s;

    // Link report from the device's own link logic
    typedef struct packed {
        logic [31:0] rate_mbps;
        logic [7:0]  duplex;
    } ncfg_link_s;

    // One packet length to be judged against the transfer-unit limit
    typedef struct packed {
        logic [15:0] length;
        logic        unsegmented;
    } ncfg_pkt_s;

endpackage

/* File: rtl/ncfg_space.sv */
// AHB-Lite slave holding the network device configuration space
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ncfg_regs.svh"

// Overview of operation
// - Configuration fields are read-only to the driver, except the offer register and the station address in legacy mode; other writes are ignored.
// - Station address is always present; meaningful only when address feature offered.
// - Link flags exist only with status feature; bit 0 link up, bit 1 announce.
// - Queue limit, rate, duplex and transfer limit read zero unless their feature offered.
// - Queue-pair limit is held between 1 and 0x8000 inclusive.
// - Transfer-unit limit lies in 68 to 65535 and never changes after reset.
// - Default transfer-unit limit is at least 1280.
// - Negotiated limit: received unsegmented packets above limit plus header are refused.
// - Negotiated limit: transmitted unsegmented packets up to limit plus header are forwarded whole.
// - Rate in Mbit/s, 0 to 0x7fffffff; larger inputs report 0xffffffff unknown.
// - Duplex reads 0x01 full, 0x00 half, any other code 0xff unknown.
// - Rate and duplex may change with a notification; frozen while link up is reported.
// - Hash key size limit reads at least 40 under steering or hash reporting.
// - Steering table limit reads at least 128 sixteen-bit entries under steering.
// - Hash kinds present under steering or reporting; encapsulation kinds under tunnel hashing.
// - Legacy mode: flags and queue limit in guest order, station address writable.
// - Only first queue pair and control queue active until the pair-count command.
module ncfg_space #(
    parameter logic [47:0] STATION_ADDR  = 48'h00_00_00_00_00_02,
    parameter logic [16:0] QP_LIMIT      = 17'h00004,
    parameter logic [15:0] MTU_LIMIT     = `NCFG_MTU_DEFAULT,
    parameter logic [7:0]  KEY_LIMIT     = 8'h28,
    parameter logic [15:0] TABLE_LIMIT   = 16'h0080,
    parameter logic [31:0] HASH_KINDS    = 32'h0000_003f,
    parameter logic [31:0] ENCAP_KINDS   = 32'h0000_0001
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [7:0]        haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              link_up_pin,
    input  wire logic              announce_pin,
    input  wire ncfg_pkg::ncfg_link_s link_report,
    input  wire logic              queue_pair_count_command,
    input  wire logic [15:0]       queue_pair_count,
    input  wire ncfg_pkg::ncfg_pkt_s rx_pkt,
    input  wire ncfg_pkg::ncfg_pkt_s tx_pkt,
    output logic                   rx_pkt_pass,
    output logic                   tx_pkt_whole,
    output logic [15:0]            active_queue_pairs,
    output logic                   config_change
);

    // ----------------------------------------------------------------
    // Fixed limits, clamped once at elaboration
    // ----------------------------------------------------------------
    localparam logic [15:0] QP_HELD =
        (QP_LIMIT == 17'h00000) ? `NCFG_QP_MIN :
        (QP_LIMIT > `NCFG_QP_MAX) ? 16'h8000 : QP_LIMIT[15:0];
    // A constant limit cannot change after it has been set
    localparam logic [15:0] MTU_HELD =
        (MTU_LIMIT < `NCFG_MTU_MIN) ? `NCFG_MTU_MIN : MTU_LIMIT;
    localparam logic [7:0]  KEY_HELD =
        (KEY_LIMIT < `NCFG_KEY_MIN) ? `NCFG_KEY_MIN : KEY_LIMIT;
    localparam logic [15:0] TABLE_HELD =
        (TABLE_LIMIT < `NCFG_TABLE_MIN) ? `NCFG_TABLE_MIN : TABLE_LIMIT;

    // ----------------------------------------------------------------
    // Synchronisers for the link pins
    // ----------------------------------------------------------------
    logic [1:0]  link_meta;
    logic [1:0]  link_sync;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_meta <= 2'h0;
            link_sync <= 2'h0;
        end else begin
            link_meta <= {announce_pin, link_up_pin};
            link_sync <= link_meta;
        end
    end

    // ----------------------------------------------------------------
    // Bus address phase capture
    // ----------------------------------------------------------------
    logic [7:0]  dp_addr;
    logic        dp_write;
    logic        dp_valid;
    wire         ap_take = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_addr  <= 8'h00;
            dp_write <= 1'b0;
            dp_valid <= 1'b0;
        end else begin
            dp_addr  <= ap_take ? haddr : dp_addr;
            dp_write <= ap_take & hwrite;
            dp_valid <= ap_take;
        end
    end

    // Zero wait states; every transfer answers OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // Offer register and write decode
    // ----------------------------------------------------------------
    ncfg_pkg::ncfg_offer_s offer;
    wire   wr_phase   = dp_valid & dp_write;
    wire   wr_offer   = wr_phase & (dp_addr == `NCFG_OFS_OFFER);
    wire   legacy_on  = offer.legacy;
    // Only legacy mode lets the driver rewrite the station address
    wire   wr_addr_lo = wr_phase & legacy_on & (dp_addr == `NCFG_OFS_ADDR_LO);
    wire   wr_addr_hi = wr_phase & legacy_on & (dp_addr == `NCFG_OFS_ADDR_HI);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            offer <= `NCFG_OFFER_RESET;
        end else if (wr_offer) begin
            offer <= hwdata[`NCFG_OFFER_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Station address
    // ----------------------------------------------------------------
    logic [47:0] station;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            station <= STATION_ADDR;
        end else begin
            station[31:0]  <= wr_addr_lo ? hwdata : station[31:0];
            station[47:32] <= wr_addr_hi ? hwdata[15:0] : station[47:32];
        end
    end

    // ----------------------------------------------------------------
    // Link rate and duplex, frozen while link up is reported
    // ----------------------------------------------------------------
    logic [31:0] rate_held;
    logic [7:0]  duplex_held;
    logic [7:0]  change_count;

    wire [31:0] rate_code =
        (link_report.rate_mbps > `NCFG_RATE_MAX) ? `NCFG_RATE_UNKNOWN : link_report.rate_mbps;
    wire        duplex_known =
        (link_report.duplex == `NCFG_DUPLEX_FULL) | (link_report.duplex == `NCFG_DUPLEX_HALF);
    wire [7:0]  duplex_code  = duplex_known ? link_report.duplex : `NCFG_DUPLEX_UNKNOWN;
    wire        freeze       = offer.status & offer.speed_duplex & link_sync[0];
    wire        rate_moves   = (rate_code != rate_held) | (duplex_code != duplex_held);
    wire        take_rate    = ~freeze & rate_moves;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate_held     <= `NCFG_RATE_UNKNOWN;
            duplex_held   <= `NCFG_DUPLEX_UNKNOWN;
            config_change <= 1'b0;
            change_count  <= 8'h00;
        end else begin
            rate_held     <= take_rate ? rate_code : rate_held;
            duplex_held   <= take_rate ? duplex_code : duplex_held;
            // Notification only when the driver can see the fields
            config_change <= take_rate & offer.speed_duplex;
            change_count  <= change_count + {7'h00, take_rate & offer.speed_duplex};
        end
    end

    // ----------------------------------------------------------------
    // Active queue pairs
    // ----------------------------------------------------------------
    wire        qp_allowed = offer.multiqueue | offer.rss;
    wire        qp_in_range = (queue_pair_count != 16'h0000) & (queue_pair_count <= QP_HELD);
    wire        qp_take    = queue_pair_count_command & qp_allowed & qp_in_range;

    // Out-of-range counts are dropped, leaving the previous count in force
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_queue_pairs <= `NCFG_QP_MIN;
        end else if (qp_take) begin
            active_queue_pairs <= queue_pair_count;
        end
    end

    // ----------------------------------------------------------------
    // Packet length decisions against the transfer-unit limit
    // ----------------------------------------------------------------
    wire [16:0] frame_limit = {1'b0, MTU_HELD} + `NCFG_ETH_HDR_LEN;
    wire        limit_on    = offer.mtu & offer.mtu_negotiated;
    wire        rx_fits     = {1'b0, rx_pkt.length} <= frame_limit;
    wire        tx_fits     = {1'b0, tx_pkt.length} <= frame_limit;

    // Segmented packets are not judged here; the segmenter owns them
    assign rx_pkt_pass  = ~(limit_on & rx_pkt.unsegmented) | rx_fits;
    assign tx_pkt_whole = limit_on & tx_pkt.unsegmented & tx_fits;

    // ----------------------------------------------------------------
    // Field presence and byte order
    // ----------------------------------------------------------------
    wire        swap16     = legacy_on & offer.guest_big_endian;
    wire [15:0] flags_raw  =
        (link_sync[0] ? `NCFG_FLAG_LINK_UP : 16'h0000) |
        (link_sync[1] ? `NCFG_FLAG_ANNOUNCE : 16'h0000);
    wire [15:0] flags_le   = offer.status ? flags_raw : 16'h0000;
    wire [15:0] qp_le      = qp_allowed ? QP_HELD : 16'h0000;
    wire [15:0] flags_out  = swap16 ? {flags_le[7:0], flags_le[15:8]} : flags_le;
    wire [15:0] qp_out     = swap16 ? {qp_le[7:0], qp_le[15:8]} : qp_le;
    wire [15:0] mtu_out    = offer.mtu ? MTU_HELD : 16'h0000;
    wire [31:0] rate_out   = offer.speed_duplex ? rate_held : 32'h0000_0000;
    wire [7:0]  duplex_out = offer.speed_duplex ? duplex_held : 8'h00;
    wire        hash_on    = offer.rss | offer.hash_report;
    wire [7:0]  key_out    = hash_on ? KEY_HELD : 8'h00;
    wire [15:0] table_out  = offer.rss ? TABLE_HELD : 16'h0000;
    wire [31:0] kinds_out  = hash_on ? HASH_KINDS : 32'h0000_0000;
    wire [31:0] encap_out  = offer.hash_tunnel ? ENCAP_KINDS : 32'h0000_0000;

    // ----------------------------------------------------------------
    // Read decode: fields packed back to back, lowest byte first
    // ----------------------------------------------------------------
    wire [31:0] word_addr_lo = station[31:0];
    wire [31:0] word_addr_hi = {flags_out, station[47:32]};
    wire [31:0] word_qp_mtu  = {mtu_out, qp_out};
    wire [31:0] word_dup_rss = {table_out, key_out, duplex_out};
    wire [31:0] word_offer   = {21'h000000, offer};
    wire [31:0] word_state   = {7'h00, link_sync[0], change_count, active_queue_pairs};

    logic [31:0] read_word;

    always_comb begin
        case (haddr)
            `NCFG_OFS_ADDR_LO:     read_word = word_addr_lo;
            `NCFG_OFS_ADDR_HI:     read_word = word_addr_hi;
            `NCFG_OFS_QP_MTU:      read_word = word_qp_mtu;
            `NCFG_OFS_RATE:        read_word = rate_out;
            `NCFG_OFS_DUPLEX_RSS:  read_word = word_dup_rss;
            `NCFG_OFS_HASH_KINDS:  read_word = kinds_out;
            `NCFG_OFS_ENCAP_KINDS: read_word = encap_out;
            `NCFG_OFS_OFFER:       read_word = word_offer;
            `NCFG_OFS_STATE:       read_word = word_state;
            default:               read_word = 32'h0000_0000;
        endcase
    end

    // Read data is sampled in the address phase, so a write to the same
    // word in the preceding data phase is not yet visible to it
    wire rd_take = ap_take & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= read_word;
        end
    end

endmodule
`default_nettype wire

/* File: dv/ncfg_space_sva.sv */
// Port-level property checker for the network configuration space
`timescale 1ns/10ps
`default_nettype none
module ncfg_space_sva (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [7:0]           haddr,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    input wire logic                 queue_pair_count_command,
    input wire logic [15:0]          queue_pair_count,
    input wire ncfg_pkg::ncfg_pkt_s  rx_pkt,
    input wire ncfg_pkg::ncfg_pkt_s  tx_pkt,
    input wire logic                 rx_pkt_pass,
    input wire logic                 tx_pkt_whole,
    input wire logic [15:0]          active_queue_pairs,
    input wire logic                 config_change
);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    wire rd_take;
    assign rd_take = hsel & htrans[1] & hready & !hwrite;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_bus_okay_ready: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_read_data_hold: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_take && haddr == 8'h1c |=> hrdata == 32'h0)
        else $error("unmapped word read nonzero");
    a_pairs_in_range: assert property (active_queue_pairs >= 16'h0001 && active_queue_pairs <= 16'h8000)
        else $error("active pairs out of range");
    a_pairs_zero_refused: assert property (queue_pair_count_command && queue_pair_count == 16'h0
        |=> $stable(active_queue_pairs))
        else $error("zero pair count accepted");
    a_pairs_idle_stable: assert property (!queue_pair_count_command |=> $stable(active_queue_pairs))
        else $error("active pairs moved without command");
    a_rx_segmented_pass: assert property (!rx_pkt.unsegmented |-> rx_pkt_pass)
        else $error("segmented receive packet blocked");
    a_rx_short_pass: assert property (rx_pkt.length <= 16'h0052 |-> rx_pkt_pass)
        else $error("packet under smallest limit blocked");
    a_tx_whole_unseg: assert property (tx_pkt_whole |-> tx_pkt.unsegmented)
        else $error("whole forwarding flagged for segmented packet");
    c_read: cover property (rd_take ##1 1'b1);
    c_change: cover property (config_change);
    c_pairs: cover property (queue_pair_count_command ##1 active_queue_pairs == 16'h0003);
    c_tx_whole: cover property (tx_pkt_whole);
endmodule

bind ncfg_space ncfg_space_sva chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .queue_pair_count_command(queue_pair_count_command), .queue_pair_count(queue_pair_count),
    .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .rx_pkt_pass(rx_pkt_pass), .tx_pkt_whole(tx_pkt_whole),
    .active_queue_pairs(active_queue_pairs), .config_change(config_change)
);
`default_nettype wire

/* File: dv/ncfg_space_tb_top.sv */
// Self-checking testbench of the network configuration space
`timescale 1ns/10ps
`default_nettype none
module ncfg_space_tb_top;
    logic                hclk, hresetn, hsel, hwrite, hreadyout, hresp, link_up_pin, announce_pin;
    logic                queue_pair_count_command, rx_pkt_pass, tx_pkt_whole, config_change;
    logic [7:0]          haddr;
    logic [1:0]          htrans;
    logic [31:0]         hwdata, hrdata, rd;
    logic [15:0]         queue_pair_count, active_queue_pairs;
    ncfg_pkg::ncfg_link_s link_report;
    ncfg_pkg::ncfg_pkt_s rx_pkt, tx_pkt;
    int                  failures = 0, checks = 0, chg_n = 0;
    logic [15:0]         qp_in [4] = '{16'h0003, 16'h0005, 16'h0000, 16'h0004};
    logic [15:0]         qp_ex [4] = '{16'h0003, 16'h0003, 16'h0003, 16'h0004};
    logic [16:0]         pk_in [3] = '{{16'h05ea, 1'b1}, {16'h05eb, 1'b1}, {16'h05eb, 1'b0}};
    logic [1:0]          pk_ex [3] = '{2'b11, 2'b00, 2'b10};
    ncfg_space dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .link_up_pin(link_up_pin), .announce_pin(announce_pin), .link_report(link_report),
        .queue_pair_count_command(queue_pair_count_command), .queue_pair_count(queue_pair_count),
        .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .rx_pkt_pass(rx_pkt_pass), .tx_pkt_whole(tx_pkt_whole),
        .active_queue_pairs(active_queue_pairs), .config_change(config_change)
    );
    // ----------------------------------------------------------------
    // Clock, pulse counter, watchdog
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        if (config_change === 1'b1) chg_n++;
    end
    initial begin
        repeat (50000) @(posedge hclk);
        failures++;
        finish_test();
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            failures++;
            finish_test();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        ahb(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 8'h00; htrans = 2'b00; hwrite = 1'b0; hwdata = 32'h0;
        link_up_pin = 1'b0; announce_pin = 1'b0; link_report = '{32'h000003e8, 8'h01};
        queue_pair_count_command = 1'b0; queue_pair_count = 16'h0000;
        rx_pkt = '{16'h0000, 1'b0}; tx_pkt = '{16'h0000, 1'b0};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(8'h00, 32'h00000002, "addr_lo");
        rchk(8'h04, 32'h00000000, "flags_absent");
        for (int i = 2; i < 7; i++) rchk(8'(i * 4), 32'h0, "field_absent");
        rchk(8'h24, 32'h00000001, "state_reset");
        ahb(1'b1, 8'h00, 32'hdeadbeef);
        rchk(8'h00, 32'h00000002, "addr_ro");
        ahb(1'b1, 8'h1c, 32'hffffffff);
        rchk(8'h1c, 32'h00000000, "unmapped");
        ahb(1'b1, 8'h20, 32'h000000ff);
        rchk(8'h20, 32'h000000ff, "offer");
        rchk(8'h08, 32'h05dc0004, "mtu_qp");
        rchk(8'h0c, 32'h000003e8, "rate");
        rchk(8'h10, 32'h00802801, "dup_key_tbl");
        rchk(8'h14, 32'h0000003f, "hash_kinds");
        rchk(8'h18, 32'h00000001, "encap_kinds");
        link_up_pin <= 1'b1;
        announce_pin <= 1'b1;
        repeat (4) @(posedge hclk);
        rchk(8'h04, 32'h00030000, "flags_up");
        link_report <= '{32'h000007d0, 8'h00};
        repeat (4) @(posedge hclk);
        rchk(8'h0c, 32'h000003e8, "rate_frozen");
        link_up_pin <= 1'b0;
        announce_pin <= 1'b0;
        repeat (6) @(posedge hclk);
        rchk(8'h0c, 32'h000007d0, "rate_new");
        rchk(8'h10, 32'h00802800, "dup_half");
        link_report <= '{32'h80000000, 8'h05};
        repeat (4) @(posedge hclk);
        rchk(8'h0c, 32'hffffffff, "rate_unknown");
        rchk(8'h10, 32'h008028ff, "dup_unknown");
        link_report <= '{32'h7fffffff, 8'h01};
        repeat (4) @(posedge hclk);
        rchk(8'h0c, 32'h7fffffff, "rate_max");
        chk("change_pulses", 32'd3, 32'(chg_n));
        rchk(8'h24, 32'h00030001, "state_changes");
        for (int i = 0; i < 4; i++) begin
            @(posedge hclk);
            queue_pair_count_command <= 1'b1;
            queue_pair_count <= qp_in[i];
            @(posedge hclk);
            queue_pair_count_command <= 1'b0;
            @(posedge hclk);
            #1 chk("active_pairs", {16'h0, qp_ex[i]}, {16'h0, active_queue_pairs});
        end
        // Limit active: 1500 plus 14 header bytes
        ahb(1'b1, 8'h20, 32'h000004ff);
        for (int i = 0; i < 3; i++) begin
            @(posedge hclk);
            rx_pkt <= pk_in[i];
            tx_pkt <= pk_in[i];
            @(posedge hclk);
            #1 chk("rx_pass", {31'h0, pk_ex[i][1]}, {31'h0, rx_pkt_pass});
            chk("tx_whole", {31'h0, pk_ex[i][0]}, {31'h0, tx_pkt_whole});
        end
        ahb(1'b1, 8'h20, 32'h000001ff);
        ahb(1'b1, 8'h00, 32'h12345678);
        rchk(8'h00, 32'h12345678, "addr_legacy");
        ahb(1'b1, 8'h20, 32'h000003ff);
        rchk(8'h08, 32'h05dc0400, "qp_swapped");
        finish_test();
    end
endmodule
`default_nettype wire
